// ===== common/rsm_pkg.sv
`default_nettype none
package rsm_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int GLITCH_NS = 50;
  localparam int GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DETECT_MAX_NS = 4000;
  localparam int DETECT_CYC = DETECT_MAX_NS / CLK_PERIOD_NS;
  localparam int RESET_HOLD_CYC = 2048;
  localparam int STOP_EXIT_HALF_CYC = 256;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_CLK_CTRL = 8'hF0;
  localparam logic [7:0] ADDR_CLK_FLAG = 8'hF2;
  localparam logic [7:0] ADDR_PLL_CONFIG = 8'hF6;
  localparam logic [7:0] ADDR_WDG_PERIOD_LO = 8'hF8;
  localparam logic [7:0] ADDR_WDG_PERIOD_HI = 8'hF9;
  localparam logic [7:0] ADDR_WDG_CTRL = 8'hFC;
  localparam logic [7:0] ADDR_WDG_SERVICE = 8'hFD;
  // ==========================================================
  // Field positions
  localparam int BIT_HALT_RST_EN = 3;
  localparam int BIT_EXT_STOP = 7;
  localparam int BIT_WDG_FLAG = 6;
  localparam int BIT_SOFT_FLAG = 5;
  localparam int BIT_PLL_SEL = 0;
  localparam int MULT_LSB = 4;
  localparam int DIV_LSB = 0;
  localparam int BIT_WDG_MODE_N = 0;
  // ==========================================================
  // Reset values and codes
  localparam logic [1:0] MULT_RESET = 2'h0;
  localparam logic [2:0] DIV_RESET = 3'h7;
  localparam logic [2:0] DIV_OFF = 3'h7;
  localparam logic [15:0] WDG_PERIOD_RESET = 16'hFFFF;
  localparam logic [7:0] WDG_KEY1 = 8'hAA;
  localparam logic [7:0] WDG_KEY2 = 8'h55;
  typedef enum logic [2:0] {
    ST_PIN = 3'h0,
    ST_DETECT = 3'h1,
    ST_HOLD = 3'h3,
    ST_BOOT = 3'h2,
    ST_VECTOR = 3'h6,
    ST_RUN = 3'h7,
    ST_HALT = 3'h5,
    ST_STOP = 3'h4
  } state_type;
  function automatic logic [3:0] mult_factor(input logic [1:0] code);
    unique case (code)
      2'h2: mult_factor = 4'hE;
      2'h0: mult_factor = 4'hA;
      2'h3: mult_factor = 4'h8;
      2'h1: mult_factor = 4'h6;
    endcase
  endfunction : mult_factor
endpackage : rsm_pkg
`default_nettype wire

// ===== logic/reset_stop_manager.sv
`default_nettype none
module reset_stop_manager
  import rsm_pkg::*;
#(
  parameter int RESET_HOLD_COUNT = RESET_HOLD_CYC,
  parameter int STOP_EXIT_COUNT = STOP_EXIT_HALF_CYC,
  parameter int DETECT_DELAY = 4,
  parameter bit ROMLESS = 1'b0
)
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic rst_pin_n_i,
  input wire logic stop_pin_n_i,
  input wire logic halt_exec_i,
  input wire logic boot_done_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic core_rst_o,
  output logic io_pullup_o,
  output logic boot_active_o,
  output logic vector_load_o,
  output logic osc_enable_o,
  output logic osc_clock_high_o,
  output logic [3:0] pll_mult_o,
  output logic [2:0] pll_div_o,
  output logic pll_on_o,
  output logic pll_clock_select_o,
  output logic ext_mem_mode_o
);
  // ==========================================================
  // State
  state_type state_r, state_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [3:0] flt_r, flt_nxt;
  logic [15:0] wdg_cnt_r, wdg_cnt_nxt;
  logic [15:0] wdg_period_r, wdg_period_nxt;
  logic wdg_armed_r, wdg_armed_nxt;
  logic watchdog_mode_n_r, watchdog_mode_n_nxt;
  logic halt_reset_enable_r, halt_reset_enable_nxt;
  logic soft_reset_flag_r, soft_reset_flag_nxt;
  logic watchdog_reset_flag_r, watchdog_reset_flag_nxt;
  logic ext_stop_flag_r, ext_stop_flag_nxt;
  logic pll_clock_select_r, pll_clock_select_nxt;
  logic [1:0] pll_mult_sel_r, pll_mult_sel_nxt;
  logic [2:0] pll_div_sel_r, pll_div_sel_nxt;
  logic [7:0] rdata_nxt;
  logic pin_rst, in_reset, wdg_expire, int_rst, halted_next;
  logic core_rst_nxt, osc_enable_nxt;

  localparam logic [15:0] HOLD_LOAD = 16'(RESET_HOLD_COUNT - 1);
  localparam logic [15:0] STOP_LOAD = 16'(2 * STOP_EXIT_COUNT - 1);
  localparam logic [15:0] DETECT_LOAD = 16'(DETECT_DELAY - 1);
  localparam logic [3:0] FLT_LAST = 4'(GLITCH_CYC - 1);

  // ==========================================================
  // Reset sequencing and registers
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    // The pin filter counts consecutive low samples, so a short glitch never
    // reaches the sequencer.
    flt_nxt = rst_pin_n_i ? 4'h0 : ((flt_r == FLT_LAST) ? flt_r : flt_r + 4'h1);
    pin_rst = !rst_pin_n_i && (flt_r == FLT_LAST);
    in_reset = (state_r == ST_PIN) || (state_r == ST_DETECT) || (state_r == ST_HOLD);
    wdg_expire = (state_r == ST_RUN) && !watchdog_mode_n_r && (wdg_cnt_r == 16'h0000);
    int_rst = 1'b0;
    soft_reset_flag_nxt = soft_reset_flag_r;
    watchdog_reset_flag_nxt = watchdog_reset_flag_r;
    ext_stop_flag_nxt = ext_stop_flag_r;
    unique case (state_r)
      ST_PIN:
      begin
        if (rst_pin_n_i)
        begin
          state_nxt = ST_DETECT;
          cnt_nxt = DETECT_LOAD;
        end
      end
      ST_DETECT, ST_HOLD:
      begin
        if (cnt_r != 16'h0000)
          cnt_nxt = cnt_r - 16'h0001;
        else if (state_r == ST_DETECT)
        begin
          state_nxt = ST_HOLD;
          cnt_nxt = HOLD_LOAD;
        end
        else
          state_nxt = ST_BOOT;
      end
      ST_BOOT:
        if (boot_done_i)
          state_nxt = ST_VECTOR;
      ST_VECTOR:
        state_nxt = ST_RUN;
      ST_RUN:
      begin
        if (wdg_expire)
        begin
          // Internal reset skips pin detection and leaves the pin alone.
          int_rst = 1'b1;
          state_nxt = ST_HOLD;
          cnt_nxt = HOLD_LOAD;
          watchdog_reset_flag_nxt = 1'b1;
          soft_reset_flag_nxt = 1'b0;
        end
        else if (halt_exec_i && halt_reset_enable_r)
        begin
          int_rst = 1'b1;
          state_nxt = ST_HOLD;
          cnt_nxt = HOLD_LOAD;
          soft_reset_flag_nxt = 1'b1;
          watchdog_reset_flag_nxt = 1'b0;
        end
        else if (halt_exec_i && watchdog_mode_n_r)
          state_nxt = ST_HALT;
        else if (!stop_pin_n_i)
        begin
          state_nxt = ST_STOP;
          cnt_nxt = STOP_LOAD;
          ext_stop_flag_nxt = 1'b1;
        end
        // HALT with the watchdog active and halt reset disabled is ignored, so the watchdog still runs.
      end
      ST_HALT:
        state_nxt = ST_HALT;
      ST_STOP:
      begin
        if (!stop_pin_n_i)
          cnt_nxt = STOP_LOAD;
        else if (cnt_r != 16'h0000)
          cnt_nxt = cnt_r - 16'h0001;
        else
          state_nxt = ST_RUN;
      end
    endcase
    if (pin_rst)
    begin
      state_nxt = ST_PIN;
      cnt_nxt = 16'h0000;
      soft_reset_flag_nxt = 1'b0;
      watchdog_reset_flag_nxt = 1'b0;
    end
    halted_next = (state_nxt == ST_HALT) || (state_nxt == ST_STOP);

    // Register file. Defined reset values are reloaded on every reset cycle, except the soft and watchdog reset cause flags.
    halt_reset_enable_nxt = halt_reset_enable_r;
    pll_mult_sel_nxt = pll_mult_sel_r;
    pll_div_sel_nxt = pll_div_sel_r;
    pll_clock_select_nxt = pll_clock_select_r;
    watchdog_mode_n_nxt = watchdog_mode_n_r;
    wdg_period_nxt = wdg_period_r;
    wdg_armed_nxt = wdg_armed_r;
    if (wr_i && !in_reset)
    begin
      unique case (addr_i)
        ADDR_CLK_CTRL: halt_reset_enable_nxt = wdata_i[BIT_HALT_RST_EN];
        ADDR_CLK_FLAG:
        begin
          pll_clock_select_nxt = wdata_i[BIT_PLL_SEL];
          if (!wdata_i[BIT_EXT_STOP])
            ext_stop_flag_nxt = 1'b0;
        end
        ADDR_PLL_CONFIG:
        begin
          pll_mult_sel_nxt = wdata_i[MULT_LSB +: 2];
          pll_div_sel_nxt = wdata_i[DIV_LSB +: 3];
          if (wdata_i[DIV_LSB +: 3] == DIV_OFF)
            pll_clock_select_nxt = 1'b0;
        end
        ADDR_WDG_PERIOD_LO: wdg_period_nxt[7:0] = wdata_i;
        ADDR_WDG_PERIOD_HI: wdg_period_nxt[15:8] = wdata_i;
        ADDR_WDG_CTRL: watchdog_mode_n_nxt = wdata_i[BIT_WDG_MODE_N];
        default:
        begin
        end
      endcase
    end
    // A stop entry in the same cycle as a clearing write keeps the flag set.
    if ((state_r == ST_RUN) && (state_nxt == ST_STOP))
      ext_stop_flag_nxt = 1'b1;
    // Stopping the oscillator drops back to the unmultiplied clock.
    if (halted_next)
      pll_clock_select_nxt = 1'b0;

    // Watchdog: KEY1 followed by KEY2 as the next write to the service register reloads the counter.
    wdg_cnt_nxt = wdg_cnt_r;
    if (wr_i && (addr_i == ADDR_WDG_SERVICE) && !in_reset)
    begin
      wdg_armed_nxt = (wdata_i == WDG_KEY1);
      if (wdg_armed_r && (wdata_i == WDG_KEY2))
        wdg_cnt_nxt = wdg_period_r;
    end
    else if ((state_r == ST_RUN) && !watchdog_mode_n_r && (wdg_cnt_r != 16'h0000))
      wdg_cnt_nxt = wdg_cnt_r - 16'h0001;

    if (pin_rst || int_rst || in_reset)
    begin
      halt_reset_enable_nxt = 1'b0;
      pll_mult_sel_nxt = MULT_RESET;
      pll_div_sel_nxt = DIV_RESET;
      pll_clock_select_nxt = 1'b0;
      watchdog_mode_n_nxt = 1'b1;
      wdg_period_nxt = WDG_PERIOD_RESET;
      wdg_cnt_nxt = WDG_PERIOD_RESET;
      wdg_armed_nxt = 1'b0;
      ext_stop_flag_nxt = 1'b0;
    end

    rdata_nxt = 8'h00;
    if (rd_i)
    begin
      unique case (addr_i)
        ADDR_CLK_CTRL: rdata_nxt[BIT_HALT_RST_EN] = halt_reset_enable_r;
        ADDR_CLK_FLAG:
        begin
          rdata_nxt[BIT_EXT_STOP] = ext_stop_flag_r;
          rdata_nxt[BIT_WDG_FLAG] = watchdog_reset_flag_r;
          rdata_nxt[BIT_SOFT_FLAG] = soft_reset_flag_r;
          rdata_nxt[BIT_PLL_SEL] = pll_clock_select_r;
        end
        ADDR_PLL_CONFIG:
        begin
          rdata_nxt[MULT_LSB +: 2] = pll_mult_sel_r;
          rdata_nxt[DIV_LSB +: 3] = pll_div_sel_r;
        end
        ADDR_WDG_PERIOD_LO: rdata_nxt = wdg_period_r[7:0];
        ADDR_WDG_PERIOD_HI: rdata_nxt = wdg_period_r[15:8];
        ADDR_WDG_CTRL: rdata_nxt[BIT_WDG_MODE_N] = watchdog_mode_n_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
    core_rst_nxt = (state_nxt == ST_PIN) || (state_nxt == ST_DETECT) || (state_nxt == ST_HOLD);
    osc_enable_nxt = !halted_next;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= ST_PIN;
      cnt_r <= 16'h0000;
      flt_r <= 4'h0;
      wdg_cnt_r <= WDG_PERIOD_RESET;
      wdg_period_r <= WDG_PERIOD_RESET;
      wdg_armed_r <= 1'b0;
      watchdog_mode_n_r <= 1'b1;
      halt_reset_enable_r <= 1'b0;
      soft_reset_flag_r <= 1'b0;
      watchdog_reset_flag_r <= 1'b0;
      ext_stop_flag_r <= 1'b0;
      pll_clock_select_r <= 1'b0;
      pll_mult_sel_r <= MULT_RESET;
      pll_div_sel_r <= DIV_RESET;
      rdata_o <= 8'h00;
      core_rst_o <= 1'b1;
      io_pullup_o <= 1'b1;
      boot_active_o <= 1'b0;
      vector_load_o <= 1'b0;
      osc_enable_o <= 1'b1;
      osc_clock_high_o <= 1'b0;
      pll_mult_o <= mult_factor(MULT_RESET);
      pll_div_o <= DIV_RESET;
      pll_on_o <= 1'b0;
      pll_clock_select_o <= 1'b0;
      ext_mem_mode_o <= ROMLESS;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      flt_r <= flt_nxt;
      wdg_cnt_r <= wdg_cnt_nxt;
      wdg_period_r <= wdg_period_nxt;
      wdg_armed_r <= wdg_armed_nxt;
      watchdog_mode_n_r <= watchdog_mode_n_nxt;
      halt_reset_enable_r <= halt_reset_enable_nxt;
      soft_reset_flag_r <= soft_reset_flag_nxt;
      watchdog_reset_flag_r <= watchdog_reset_flag_nxt;
      ext_stop_flag_r <= ext_stop_flag_nxt;
      pll_clock_select_r <= pll_clock_select_nxt;
      pll_mult_sel_r <= pll_mult_sel_nxt;
      pll_div_sel_r <= pll_div_sel_nxt;
      rdata_o <= rdata_nxt;
      core_rst_o <= core_rst_nxt;
      io_pullup_o <= core_rst_nxt;
      boot_active_o <= (state_nxt == ST_BOOT);
      vector_load_o <= (state_nxt == ST_VECTOR);
      osc_enable_o <= osc_enable_nxt;
      osc_clock_high_o <= (state_nxt == ST_HALT);
      pll_mult_o <= mult_factor(pll_mult_sel_nxt);
      // Divider output is the divisor minus one; 7 means bypass.
      pll_div_o <= pll_div_sel_nxt;
      pll_on_o <= (pll_div_sel_nxt != DIV_OFF) && osc_enable_nxt;
      pll_clock_select_o <= pll_clock_select_nxt;
      if (core_rst_nxt)
        ext_mem_mode_o <= ROMLESS;
    end
  end

  // ==========================================================
  // Checks
  a_glitch_ignored: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_r == ST_RUN) && rst_pin_n_i ##1 !rst_pin_n_i [*5] ##1 rst_pin_n_i
    |-> ##1 (state_r != ST_PIN))
    else $error("short reset glitch caused a reset");
  a_pin_reset_enter: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !rst_pin_n_i [*8] ##1 !rst_pin_n_i ##1 !rst_pin_n_i |-> ##[1:2] core_rst_o)
    else $error("long low pin did not reset");
  a_pin_clears_flags: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_r == ST_PIN) |-> !soft_reset_flag_r && !watchdog_reset_flag_r)
    else $error("pin reset left a cause flag set");
  a_wdg_reset_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wdg_expire && rst_pin_n_i |=> watchdog_reset_flag_r && (state_r == ST_HOLD) && core_rst_o)
    else $error("watchdog expiry not recorded");
  a_halt_soft_reset: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_r == ST_RUN) && halt_exec_i && halt_reset_enable_r && !wdg_expire && rst_pin_n_i
    |=> soft_reset_flag_r && core_rst_o)
    else $error("halt reset not taken");
  a_halt_osc_high: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_r == ST_HALT) |-> osc_clock_high_o && !osc_enable_o)
    else $error("oscillator running in halt");
  a_halt_wdg_run: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_r == ST_RUN) && halt_exec_i && !watchdog_mode_n_r |=> state_r != ST_HALT)
    else $error("halt stopped oscillator with watchdog on");
  a_stop_freeze: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_r == ST_STOP) && $past(state_r == ST_STOP) && !$past(wr_i) |-> $stable(wdg_cnt_r))
    else $error("watchdog moved during stop");
  a_div_off_sel: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_i && !in_reset && (addr_i == ADDR_PLL_CONFIG) && (wdata_i[2:0] == DIV_OFF)
    |=> !pll_clock_select_o && !pll_on_o)
    else $error("pll select kept after bypass");
  a_mult_code: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    pll_mult_o == ((pll_mult_sel_r == 2'h2) ? 4'hE : (pll_mult_sel_r == 2'h0) ? 4'hA
      : (pll_mult_sel_r == 2'h3) ? 4'h8 : 4'h6))
    else $error("multiplier factor mismatch");
  a_hold_exit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_r == ST_HOLD) && (cnt_r == 16'h0000) && rst_pin_n_i |=> boot_active_o)
    else $error("boot did not follow hold");
  c_pin_boot: cover property (@(posedge clk_i) disable iff (sys_rst_i) vector_load_o);
  c_stop_exit: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_r == ST_STOP) ##1 (state_r == ST_RUN));
  c_halt: cover property (@(posedge clk_i) disable iff (sys_rst_i) state_r == ST_HALT);
  c_wdg: cover property (@(posedge clk_i) disable iff (sys_rst_i) wdg_expire);
endmodule : reset_stop_manager
`default_nettype wire

// ===== tb/board_ctrl.sv
`default_nettype none
module board_ctrl
(
  input wire logic clk_i,
  output logic rst_pin_n_o,
  output logic stop_pin_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Board pins
  // Both pins carry pull-ups on the board, so a released pin reads high.
  initial
  begin
    rst_pin_n_o = 1'b1;
    stop_pin_n_o = 1'b1;
  end

  // A short pulse exercises the glitch filter, a long one leaves HALT.
  task automatic pulse_reset(input int n);
    @(posedge clk_i);
    rst_pin_n_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    rst_pin_n_o <= 1'b1;
  endtask : pulse_reset

  task automatic pulse_stop(input int n);
    @(posedge clk_i);
    stop_pin_n_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    stop_pin_n_o <= 1'b1;
  endtask : pulse_stop
endmodule : board_ctrl
`default_nettype wire

// ===== tb/tb_reset_stop_manager.sv
`default_nettype none
module tb_reset_stop_manager
  import rsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HOLD = 8;
  localparam int SEXIT = 4;
  localparam int DET = 4;
  // Lock-in wait granted to the PLL before software selects it as system clock.
  localparam int LOCK = 20;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic halt_exec_i = 1'b0;
  logic boot_done_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  wire logic rst_pin_n;
  wire logic stop_pin_n;
  logic [7:0] rdata_o;
  logic core_rst_o, io_pullup_o, boot_active_o, vector_load_o, osc_enable_o;
  logic osc_clock_high_o, pll_on_o, pll_clock_select_o, ext_mem_mode_o;
  logic [3:0] pll_mult_o;
  logic [2:0] pll_div_o;
  logic [7:0] rdv;
  logic hi;
  int errors = 0;
  int n_compared = 0;
  int w;
  int vc;
  logic [3:0] fac [4] = '{4'hA, 4'h6, 4'hE, 4'h8};

  always #2.5 clk_i = ~clk_i;

  board_ctrl i_board (.clk_i(clk_i), .rst_pin_n_o(rst_pin_n), .stop_pin_n_o(stop_pin_n));

  reset_stop_manager #(.RESET_HOLD_COUNT(HOLD), .STOP_EXIT_COUNT(SEXIT), .DETECT_DELAY(DET),
    .ROMLESS(1'b0)) i_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .rst_pin_n_i(rst_pin_n),
    .stop_pin_n_i(stop_pin_n), .halt_exec_i(halt_exec_i), .boot_done_i(boot_done_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .core_rst_o(core_rst_o), .io_pullup_o(io_pullup_o), .boot_active_o(boot_active_o),
    .vector_load_o(vector_load_o), .osc_enable_o(osc_enable_o),
    .osc_clock_high_o(osc_clock_high_o), .pll_mult_o(pll_mult_o), .pll_div_o(pll_div_o),
    .pll_on_o(pll_on_o), .pll_clock_select_o(pll_clock_select_o),
    .ext_mem_mode_o(ext_mem_mode_o));

  // ==========================================================
  // Checking helpers
  `define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
  `define WAITC(c) for (w = 0; w < 400 && (c) !== 1'b1; w++) begin @(posedge clk_i); #1; end \
    if ((c) !== 1'b1) begin errors++; summarize(); end

  task automatic summarize();
    if (errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // ==========================================================
  // Register port and CPU strobes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rdv = rdata_o;
  endtask : rd

  task automatic halt();
    @(posedge clk_i);
    halt_exec_i <= 1'b1;
    @(posedge clk_i);
    halt_exec_i <= 1'b0;
    #1;
  endtask : halt

  // Waits out reset, finishes the boot routine and expects one vector load.
  task automatic reboot();
    `WAITC(boot_active_o)
    @(posedge clk_i);
    boot_done_i <= 1'b1;
    @(posedge clk_i);
    boot_done_i <= 1'b0;
    vc = 0;
    repeat (6)
    begin
      #1 vc += int'(vector_load_o === 1'b1);
      @(posedge clk_i);
    end
    #1;
    `CHK(vc, 1)
    `CHK({core_rst_o, io_pullup_o}, 2'b00)
  endtask : reboot

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_i);
    #1;
    `CHK({core_rst_o, io_pullup_o}, 2'b11)
    `CHK({pll_mult_o, pll_div_o, pll_on_o}, {4'hA, 3'h7, 1'b0})
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    `WAITC(boot_active_o)
    `CHK(w inside {[DET + HOLD : DET + HOLD + 3]}, 1'b1)
    `CHK(core_rst_o, 1'b0)
    @(posedge clk_i);
    boot_done_i <= 1'b1;
    @(posedge clk_i);
    boot_done_i <= 1'b0;
    `CHK(ext_mem_mode_o, 1'b0)
    rd(ADDR_PLL_CONFIG);
    `CHK(rdv, 8'h07)
    for (int m = 0; m < 4; m++)
      for (int d = 0; d < 8; d++)
      begin
        wr(ADDR_PLL_CONFIG, {2'h0, m[1:0], 1'b0, d[2:0]});
        `CHK({pll_mult_o, pll_div_o}, {fac[m], d[2:0]})
        `CHK(pll_on_o, d != 7)
        rd(ADDR_PLL_CONFIG);
        `CHK(rdv, {2'h0, m[1:0], 1'b0, d[2:0]})
      end
    wr(ADDR_PLL_CONFIG, 8'h21);
    repeat (LOCK) @(posedge clk_i);
    wr(ADDR_CLK_FLAG, 8'h01);
    `CHK(pll_clock_select_o, 1'b1)
    wr(ADDR_PLL_CONFIG, 8'h27);
    `CHK(pll_clock_select_o, 1'b0)
    rd(8'h10);
    `CHK(rdv, 8'h00)
    wr(ADDR_PLL_CONFIG, 8'h32);
    i_board.pulse_reset(5);
    hi = 1'b0;
    repeat (15)
    begin
      @(posedge clk_i);
      #1 hi |= core_rst_o;
    end
    `CHK(hi, 1'b0)
    i_board.pulse_reset(20);
    #1;
    `CHK(core_rst_o, 1'b1)
    reboot();
    rd(ADDR_PLL_CONFIG);
    `CHK(rdv, 8'h07)
    rd(ADDR_CLK_FLAG);
    `CHK(rdv[6:5], 2'b00)
    halt();
    `CHK({osc_enable_o, osc_clock_high_o}, 2'b01)
    repeat (30) @(posedge clk_i);
    #1;
    `CHK({osc_enable_o, core_rst_o}, 2'b00)
    i_board.pulse_reset(20);
    reboot();
    `CHK(osc_enable_o, 1'b1)
    wr(ADDR_CLK_CTRL, 8'h08);
    halt();
    `CHK(core_rst_o, 1'b1)
    reboot();
    rd(ADDR_CLK_FLAG);
    `CHK(rdv[6:5], 2'b01)
    wr(ADDR_WDG_PERIOD_LO, 8'h40);
    wr(ADDR_WDG_PERIOD_HI, 8'h00);
    wr(ADDR_WDG_CTRL, 8'h00);
    wr(ADDR_WDG_SERVICE, WDG_KEY1);
    wr(ADDR_WDG_SERVICE, WDG_KEY2);
    halt();
    `CHK({osc_enable_o, core_rst_o}, 2'b10)
    // A stop longer than the period proves the watchdog count is frozen.
    i_board.pulse_stop(100);
    #1;
    `CHK(osc_enable_o, 1'b0)
    `WAITC(osc_enable_o)
    `CHK(w inside {[2 * SEXIT - 1 : 2 * SEXIT + 2]}, 1'b1)
    `CHK(core_rst_o, 1'b0)
    rd(ADDR_CLK_FLAG);
    `CHK(rdv[7], 1'b1)
    `WAITC(core_rst_o)
    `CHK(rst_pin_n, 1'b1)
    // An internal reset skips pin detection, so boot follows after the hold count alone.
    `WAITC(boot_active_o)
    `CHK(w inside {[HOLD : HOLD + 1]}, 1'b1)
    reboot();
    rd(ADDR_CLK_FLAG);
    `CHK(rdv[6:5], 2'b10)
    summarize();
  end

  initial
  begin
    #(100000 * 5);
    errors++;
    summarize();
  end
endmodule : tb_reset_stop_manager
`default_nettype wire
